// ===== common/stw_defines.svh
`ifndef STW_DEFINES_SVH
`define STW_DEFINES_SVH
`define STW_ADDR_DEFAULT 7'h70
`define STW_BCAST_WR 8'h00
`define STW_BCAST_RD 8'h01
`define STW_GC_RESET_CMD 8'h06
`define STW_HS_CODE 5'h01
`define STW_PTR_RESET 8'h00
`define STW_SEL_TEMP 2'h0
`define STW_BYTE_BITS 4'h8
`define STW_IDLE_BYTE 8'hFF
`define STW_LAST_SLOT 3'h7
`define STW_PIN_IDLE 2'h3
`define STW_TIMEOUT_MS 30
`define STW_CLK_HZ 25000000
`endif

// ===== common/stw_pkg.sv
package stw_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK,
        ST_WDATA, ST_DACK, ST_TX, ST_MACK, ST_IGNORE
    } stw_state_t;
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] data;
    } stw_word_t;
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } stw_sync_st_t;
    typedef struct packed {
        stw_word_t out_word;
        logic out_valid;
        stw_word_t skid_word;
        logic skid_valid;
    } stw_buf_st_t;
    typedef struct packed {
        stw_state_t fsm;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic bcast;
        logic gcall;
        logic gcdone;
        logic acked;
        logic [2:0] slot;
        logic [7:0] register_select_pointer;
        logic hs;
        logic sda_o;
        logic sda_oe_n;
        logic gc_pulse;
        logic push;
        stw_word_t wword;
        logic [19:0] tocnt;
    } stw_top_st_t;
endpackage : stw_pkg

// ===== common/stw_strm_if.sv
`timescale 1ns/1ps
interface stw_strm_if;
    import stw_pkg::*;
    logic valid;
    logic ready;
    stw_word_t word;
    modport src(output valid, output word, input ready);
    modport snk(input valid, input word, output ready);
endinterface : stw_strm_if

// ===== src/stw_sync.sv
`timescale 1ns/1ps
`include "stw_defines.svh"
module stw_sync
    import stw_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] pin_in,
    output logic [1:0] lvl,
    output logic [1:0] prev
);
    stw_sync_st_t st_reg;
    stw_sync_st_t st_next;

    // s1 feeds only s2; s3 is one cycle of history for edge finding
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= {`STW_PIN_IDLE, `STW_PIN_IDLE, `STW_PIN_IDLE};
        end else begin
            st_reg <= st_next;
        end
    end

    assign lvl = st_reg.s2;
    assign prev = st_reg.s3;
endmodule : stw_sync

// ===== src/stw_buf.sv
`timescale 1ns/1ps
module stw_buf
    import stw_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    stw_strm_if.snk in_s,
    stw_strm_if.src out_s
);
    stw_buf_st_t st_reg;
    stw_buf_st_t st_next;

    // two entries: output register plus skid register
    always_comb begin
        st_next = st_reg;
        if (out_s.ready || !st_reg.out_valid) begin
            if (st_reg.skid_valid) begin
                st_next.out_word = st_reg.skid_word;
                st_next.out_valid = 1'b1;
                st_next.skid_valid = 1'b0;
            end else begin
                st_next.out_word = in_s.word;
                st_next.out_valid = in_s.valid;
            end
        end else if (in_s.valid && !st_reg.skid_valid) begin
            st_next.skid_word = in_s.word;
            st_next.skid_valid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_s.ready = !st_reg.skid_valid;
    assign out_s.valid = st_reg.out_valid;
    assign out_s.word = st_reg.out_word;
endmodule : stw_buf

// ===== src/stw_slave.sv
`timescale 1ns/1ps
`include "stw_defines.svh"
// Contract
// - start: sda falls while scl high
// - address sampled on rise, ninth pulse ack
// - eight data pulses then one ack
// - sda change with scl high is start/stop
// - stop: sda rises while scl high, idle
// - slave only, sda open-drain low only
// - every byte shifted msb first
// - answer one parameter address 1110000-1110111
// - first written byte loads the pointer
// - pointer kept until rewritten or reset
// - receive: ack address, pointer, data byte; code nacks the data byte while the write buffer is full
// - transmit pointed byte after address ack
// - general call 0x06 restores power-up values
// - hs master code: no ack, hs on
// - hs stays until a stop
// - scl low 30 ms resets interface
// - ack broadcast read and write addresses
// - broadcast write: ack pointer, store data
// - broadcast read: drive only own slot
// - slot nack stops later slots
// - pointer select bits reset to 00
// - select 00 temperature read only
// - register write only at byte end
module stw_slave
    import stw_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `STW_ADDR_DEFAULT,
    parameter int unsigned TIMEOUT_CYC = `STW_TIMEOUT_MS * (`STW_CLK_HZ / 1000)
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic hs_mode,
    output logic [1:0] reg_sel,
    input wire logic [7:0] rd_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [1:0] wr_sel,
    output logic [7:0] wr_data,
    output logic gc_reset
);
    localparam logic [19:0] TO_LAST = 20'(TIMEOUT_CYC - 1);

    stw_top_st_t st_reg;
    stw_top_st_t st_next;
    logic [1:0] pin_lvl;
    logic [1:0] pin_prev;
    logic scl_lvl;
    logic sda_lvl;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic tmo;
    logic byte_done;

    stw_strm_if wr_in ();
    stw_strm_if wr_out ();

    stw_sync u_sync (
        .clk(clk),
        .srst(srst),
        .pin_in({scl_in, sda_in}),
        .lvl(pin_lvl),
        .prev(pin_prev)
    );

    stw_buf u_buf (
        .clk(clk),
        .srst(srst),
        .in_s(wr_in.snk),
        .out_s(wr_out.src)
    );

    // byte to shift out in a slot; foreign broadcast slots stay released
    function automatic logic [7:0] slot_byte(
        input logic bc,
        input logic [2:0] slot,
        input logic [7:0] rd
    );
        if (bc && (slot != DEV_ADDR[2:0])) begin
            slot_byte = `STW_IDLE_BYTE;
        end else begin
            slot_byte = rd;
        end
    endfunction : slot_byte

    assign scl_lvl = pin_lvl[1];
    assign sda_lvl = pin_lvl[0];
    assign scl_rise = scl_lvl && !pin_prev[1];
    assign scl_fall = !scl_lvl && pin_prev[1];
    assign start_det = scl_lvl && pin_prev[1] && !sda_lvl && pin_prev[0];
    assign stop_det = scl_lvl && pin_prev[1] && sda_lvl && !pin_prev[0];
    assign tmo = !scl_lvl && (st_reg.tocnt == TO_LAST);
    assign byte_done = scl_fall && (st_reg.bitcnt == `STW_BYTE_BITS);

    always_comb begin
        st_next = st_reg;
        st_next.gc_pulse = 1'b0;
        st_next.push = 1'b0;
        st_next.sda_o = 1'b0;
        if (scl_lvl) begin
            st_next.tocnt = '0;
        end else if (!tmo) begin
            st_next.tocnt = st_reg.tocnt + 20'h00001;
        end
        if (stop_det) begin
            st_next.fsm = ST_IDLE;
            st_next.sda_oe_n = 1'b1;
            st_next.hs = 1'b0;
        end else if (start_det) begin
            st_next.fsm = ST_ADDR;
            st_next.bitcnt = '0;
            st_next.sda_oe_n = 1'b1;
            st_next.gcdone = 1'b0;
        end else if (tmo) begin
            st_next.fsm = ST_IDLE;
            st_next.sda_oe_n = 1'b1;
        end else begin
            unique case (st_reg.fsm)
                ST_IDLE, ST_IGNORE: begin
                    st_next.sda_oe_n = 1'b1;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        st_next.shreg = {st_reg.shreg[6:0], sda_lvl};
                        st_next.bitcnt = st_reg.bitcnt + 4'h1;
                    end
                    if (byte_done) begin
                        unique case (st_reg.fsm)
                            ST_ADDR: begin
                                st_next.fsm = ST_AACK;
                                st_next.sda_oe_n = 1'b0;
                                st_next.bcast = 1'b0;
                                st_next.gcall = 1'b0;
                                if (st_reg.shreg[7:1] == DEV_ADDR) begin
                                    st_next.rw = st_reg.shreg[0];
                                end else if (st_reg.shreg == `STW_BCAST_WR) begin
                                    st_next.rw = 1'b0;
                                    st_next.bcast = 1'b1;
                                    st_next.gcall = 1'b1;
                                end else if (st_reg.shreg == `STW_BCAST_RD) begin
                                    st_next.rw = 1'b1;
                                    st_next.bcast = 1'b1;
                                end else begin
                                    st_next.fsm = ST_IGNORE;
                                    st_next.sda_oe_n = 1'b1;
                                    if (st_reg.shreg[7:3] == `STW_HS_CODE) begin
                                        st_next.hs = 1'b1;
                                    end
                                end
                            end
                            ST_PTR: begin
                                st_next.fsm = ST_PACK;
                                st_next.sda_oe_n = 1'b0;
                                if (st_reg.gcall && st_reg.shreg == `STW_GC_RESET_CMD) begin
                                    st_next.gc_pulse = 1'b1;
                                    st_next.gcdone = 1'b1;
                                    st_next.register_select_pointer = `STW_PTR_RESET;
                                end else begin
                                    st_next.register_select_pointer = st_reg.shreg;
                                end
                            end
                            default: begin
                                st_next.fsm = ST_DACK;
                                if (st_reg.register_select_pointer[1:0] == `STW_SEL_TEMP) begin
                                    st_next.sda_oe_n = 1'b0;
                                end else if (wr_in.ready) begin
                                    st_next.sda_oe_n = 1'b0;
                                    st_next.push = 1'b1;
                                    st_next.wword = {st_reg.register_select_pointer[1:0],
                                                     st_reg.shreg};
                                end
                            end
                        endcase
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        st_next.bitcnt = '0;
                        if (st_reg.rw) begin
                            st_next.fsm = ST_TX;
                            st_next.slot = '0;
                            st_next.shreg = slot_byte(st_reg.bcast, 3'h0, rd_data);
                            st_next.sda_oe_n = st_next.shreg[7];
                        end else begin
                            st_next.fsm = ST_PTR;
                            st_next.sda_oe_n = 1'b1;
                        end
                    end
                end
                ST_PACK: begin
                    if (scl_fall) begin
                        st_next.sda_oe_n = 1'b1;
                        st_next.bitcnt = '0;
                        st_next.fsm = st_reg.gcdone ? ST_IGNORE : ST_WDATA;
                    end
                end
                ST_DACK: begin
                    if (scl_fall) begin
                        st_next.sda_oe_n = 1'b1;
                        st_next.fsm = ST_IGNORE;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        st_next.bitcnt = st_reg.bitcnt + 4'h1;
                    end
                    if (byte_done) begin
                        st_next.sda_oe_n = 1'b1;
                        st_next.fsm = ST_MACK;
                    end else if (scl_fall) begin
                        st_next.shreg = {st_reg.shreg[6:0], 1'b1};
                        st_next.sda_oe_n = st_reg.shreg[6];
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        st_next.acked = !sda_lvl;
                    end
                    if (scl_fall) begin
                        if (st_reg.acked && st_reg.bcast && st_reg.slot != `STW_LAST_SLOT) begin
                            st_next.slot = st_reg.slot + 3'h1;
                            st_next.shreg = slot_byte(1'b1, st_next.slot, rd_data);
                            st_next.sda_oe_n = st_next.shreg[7];
                            st_next.bitcnt = '0;
                            st_next.fsm = ST_TX;
                        end else begin
                            st_next.fsm = ST_IGNORE;
                        end
                    end
                end
                default: begin
                    st_next.fsm = ST_IDLE;
                    st_next.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.sda_oe_n <= 1'b1;
            st_reg.register_select_pointer <= `STW_PTR_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wr_in.valid = st_reg.push;
    assign wr_in.word = st_reg.wword;
    assign wr_out.ready = wr_ready;
    assign wr_valid = wr_out.valid;
    assign wr_sel = wr_out.word.sel;
    assign wr_data = wr_out.word.data;
    assign sda_out = st_reg.sda_o;
    assign sda_oe_n = st_reg.sda_oe_n;
    assign hs_mode = st_reg.hs;
    assign reg_sel = st_reg.register_select_pointer[1:0];
    assign gc_reset = st_reg.gc_pulse;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_start_addr: assert property (
        start_det |=> st_reg.fsm == ST_ADDR && st_reg.bitcnt == 4'h0 && sda_oe_n
    ) else $error("start did not open address phase");

    a_stop_idle: assert property (
        stop_det |=> st_reg.fsm == ST_IDLE && sda_oe_n && !hs_mode
    ) else $error("stop did not return to idle");

    a_addr_ack: assert property (
        (st_reg.fsm == ST_ADDR && byte_done && st_reg.shreg[7:1] == DEV_ADDR
            && !start_det && !stop_det && !tmo)
        |=> !sda_oe_n && st_reg.fsm == ST_AACK
    ) else $error("own address not acknowledged");

    a_hs_nack: assert property (
        (st_reg.fsm == ST_ADDR && byte_done && st_reg.shreg[7:3] == `STW_HS_CODE
            && !start_det && !stop_det && !tmo)
        |=> sda_oe_n && hs_mode && st_reg.fsm == ST_IGNORE
    ) else $error("master code mishandled");

    a_hs_exit: assert property (
        $fell(hs_mode) |-> $past(stop_det)
    ) else $error("hs mode left without stop");

    a_timeout: assert property (
        (tmo && !start_det && !stop_det) |=> st_reg.fsm == ST_IDLE && sda_oe_n
    ) else $error("scl low timeout did not release bus");

    a_wr_end: assert property (
        st_reg.push |-> $past(st_reg.fsm) == ST_WDATA && $past(st_reg.bitcnt) == 4'h8
    ) else $error("register write before byte end");

    a_ptr_keep: assert property (
        $changed(st_reg.register_select_pointer) |-> $past(st_reg.fsm) == ST_PTR
    ) else $error("pointer changed outside pointer byte");

    a_gc_clear: assert property (
        gc_reset |-> reg_sel == `STW_SEL_TEMP ##1 st_reg.fsm != ST_WDATA
    ) else $error("general call reset did not clear pointer");

    a_slot_quiet: assert property (
        (st_reg.fsm == ST_TX && st_reg.bcast && st_reg.slot != DEV_ADDR[2:0]) |-> sda_oe_n
    ) else $error("drove a foreign broadcast slot");

    a_sda_low: assert property (
        !sda_out
    ) else $error("sda driven high");

    c_direct_read: cover property (st_reg.fsm == ST_MACK && !st_reg.bcast);
    c_bcast_write: cover property (st_reg.push && st_reg.gcall);
    c_bcast_read: cover property (st_reg.fsm == ST_TX && st_reg.slot == DEV_ADDR[2:0]
        && st_reg.bcast);
    c_gc_reset: cover property (gc_reset);
    c_hs_entry: cover property ($rose(hs_mode));
endmodule : stw_slave

// ===== verification/stw_bus_master.sv
`timescale 1ns/1ps
module stw_bus_master (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    // both lines idle released at the pull-up level
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // waits out a trailing ack so that no false stop is seen
    task automatic start();
        sda_m = 1'b1;
        #160 scl = 1'b1;
        #80 sda_m = 1'b0;
        #80 scl = 1'b0;
    endtask : start

    task automatic stop();
        #40 sda_m = 1'b0;
        #160 scl = 1'b1;
        #80 sda_m = 1'b1;
        #160;
    endtask : stop

    // 320 ns bit: data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        #40 sda_m = b;
        #160 scl = 1'b1;
        #60 r = sda;
        #60 scl = 1'b0;
    endtask : bit_io

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wbyte

    task automatic rbyte(input logic mack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(~mack, r);
    endtask : rbyte
endmodule : stw_bus_master

// ===== verification/stw_slave_bench.sv
`timescale 1ns/1ps
module stw_slave_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr_ready = 1'b1;
    logic scl;
    logic sda_m;
    wire sda;
    logic sda_out;
    logic sda_oe_n;
    logic hs_mode;
    logic [1:0] reg_sel;
    logic [7:0] rd_data;
    logic wr_valid;
    logic [1:0] wr_sel;
    logic [7:0] wr_data;
    logic gc_reset;
    logic [7:0] regs [4] = '{8'h00, 8'h02, 8'hF6, 8'h3C};
    logic [7:0] last_data;
    logic [1:0] last_sel;
    int wr_cnt = 0;
    int gc_cnt = 0;
    int cyc = 0;
    int bad_count = 0;
    int num_checks = 0;

    always #20 clk = ~clk;
    assign sda = sda_m & (sda_oe_n | sda_out);
    assign rd_data = regs[reg_sel];

    stw_slave #(.DEV_ADDR(7'h72), .TIMEOUT_CYC(200)) uut (
        .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .hs_mode(hs_mode),
        .reg_sel(reg_sel), .rd_data(rd_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_sel(wr_sel), .wr_data(wr_data),
        .gc_reset(gc_reset)
    );
    stw_bus_master m (.scl(scl), .sda_m(sda_m), .sda(sda));

    // register contents outside the block take written words
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (gc_reset === 1'b1) begin
            gc_cnt <= gc_cnt + 1;
        end
        if (wr_valid === 1'b1 && wr_ready) begin
            regs[wr_sel] <= wr_data;
            last_sel <= wr_sel;
            last_data <= wr_data;
            wr_cnt <= wr_cnt + 1;
        end
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {7'h00, e}, {7'h00, g});
    endtask : chk1

    task automatic send(input logic [7:0] b, input logic e);
        logic a;
        m.wbyte(b, a);
        chk1("ack", e, a);
    endtask : send

    task automatic recv(input logic mack, input logic [7:0] e);
        logic [7:0] b;
        m.rbyte(mack, b);
        chk("rdata", e, b);
    endtask : recv

    task automatic t_write();
        chk1("oe_n", 1'b1, sda_oe_n);
        chk("sel", 8'h00, {6'h00, reg_sel});
        m.start();
        send(8'hE4, 1'b1);
        send(8'h01, 1'b1);
        chk1("early", 1'b0, wr_valid);
        send(8'hA5, 1'b1);
        m.stop();
        chk1("idle", 1'b1, sda_oe_n);
        chk("wsel", 8'h01, {6'h00, last_sel});
        chk("wdata", 8'hA5, last_data);
    endtask : t_write

    task automatic t_read();
        m.start();
        send(8'hE4, 1'b1);
        send(8'h02, 1'b1);
        m.start();
        send(8'hE5, 1'b1);
        recv(1'b0, 8'hF6);
        m.stop();
        m.start();
        send(8'hE5, 1'b1);
        recv(1'b0, 8'hF6);
        m.stop();
        chk("sel", 8'h02, {6'h00, reg_sel});
    endtask : t_read

    task automatic t_misc();
        int n;
        n = wr_cnt;
        m.start();
        send(8'hE6, 1'b0);
        m.stop();
        m.start();
        send(8'hE4, 1'b1);
        send(8'h00, 1'b1);
        send(8'h77, 1'b1);
        m.stop();
        chk("count", 8'(n), 8'(wr_cnt));
        m.start();
        send(8'hE4, 1'b1);
        send(8'h03, 1'b1);
        m.stop();
        n = gc_cnt;
        m.start();
        send(8'h00, 1'b1);
        send(8'h06, 1'b1);
        m.stop();
        chk("gc", 8'(n + 1), 8'(gc_cnt));
        chk("sel", 8'h00, {6'h00, reg_sel});
    endtask : t_misc

    task automatic t_hs();
        for (int i = 8; i < 16; i++) begin
            m.start();
            send(8'(i), 1'b0);
            chk1("hs", 1'b1, hs_mode);
            m.stop();
            chk1("hs", 1'b0, hs_mode);
        end
        m.start();
        send(8'h0D, 1'b0);
        m.start();
        send(8'hE4, 1'b1);
        send(8'h00, 1'b1);
        m.start();
        chk1("hs", 1'b1, hs_mode);
        m.stop();
        chk1("hs", 1'b0, hs_mode);
    endtask : t_hs

    task automatic t_bcast();
        m.start();
        send(8'h00, 1'b1);
        send(8'h03, 1'b1);
        send(8'h5A, 1'b1);
        m.stop();
        chk("bc", 8'h5A, regs[3]);
        m.start();
        send(8'h01, 1'b1);
        for (int i = 0; i < 8; i++) begin
            recv(1'b1, (i == 2) ? 8'h5A : 8'hFF);
        end
        m.stop();
        m.start();
        send(8'h01, 1'b1);
        for (int i = 0; i < 4; i++) begin
            recv(i != 1, 8'hFF);
        end
        m.stop();
    endtask : t_bcast

    // receiver stalls: third word is refused, the two held drain in order
    task automatic t_buf();
        int n;
        n = wr_cnt;
        @(posedge clk);
        wr_ready <= 1'b0;
        #7;
        for (int i = 0; i < 3; i++) begin
            m.start();
            send(8'hE4, 1'b1);
            send(8'h01, 1'b1);
            send(8'(8'h11 * (i + 1)), i < 2);
            m.stop();
        end
        chk1("full", 1'b1, wr_valid);
        @(posedge clk);
        wr_ready <= 1'b1;
        repeat (4) @(posedge clk);
        #7;
        chk("drain", 8'(n + 2), 8'(wr_cnt));
        chk("order", 8'h22, regs[1]);
        chk1("empty", 1'b0, wr_valid);
    endtask : t_buf

    task automatic t_timeout();
        logic r;
        logic [7:0] b;
        b = 8'hE4;
        m.start();
        for (int i = 7; i >= 0; i--) begin
            m.bit_io(b[i], r);
        end
        #200;
        chk1("ack_low", 1'b0, sda_oe_n);
        repeat (220) @(posedge clk);
        #7;
        chk1("released", 1'b1, sda_oe_n);
        m.start();
        send(8'hE4, 1'b1);
        send(8'h01, 1'b1);
        m.stop();
    endtask : t_timeout

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        #7;
        t_write();
        t_read();
        t_misc();
        t_hs();
        t_bcast();
        t_buf();
        t_timeout();
        test_done();
    end
endmodule : stw_slave_bench
